// File: sccf_pkg.sv
`default_nettype none
package sccf_pkg;

  localparam int unsigned CLK_HZ = 100_000_000;

  // Lock retry on-window in ms and off/on ratio
  localparam int unsigned LOCK_ON_MS = 420;
  localparam int unsigned LOCK_OFF_RATIO = 10;
  // PWM-low standby timeout in ms
  localparam int unsigned STBY_TIMEOUT_MS = 65;
  // Hall settling after wake in us
  localparam int unsigned HALL_SETTLE_US = 100;
  // Soft commutation transition in us
  localparam int unsigned SOFT_SW_US = 200;

  localparam int unsigned LOCK_ON_CYC = LOCK_ON_MS * (CLK_HZ / 1000);
  localparam int unsigned LOCK_OFF_CYC = LOCK_ON_CYC * LOCK_OFF_RATIO;
  localparam int unsigned STBY_CYC = STBY_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned HALL_SETTLE_CYC = HALL_SETTLE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SOFT_SW_CYC = SOFT_SW_US * (CLK_HZ / 1_000_000);

  // Resolution of the soft-switch duty crossfade
  localparam int unsigned SOFT_LEVEL_W = 8;
  localparam int unsigned TIMER_W = 32;

  typedef enum logic [1:0] {
    ST_STANDBY  = 2'b00,
    ST_SETTLE   = 2'b01,
    ST_RUN      = 2'b10,
    ST_LOCK_OFF = 2'b11
  } sccf_state_e;

  typedef struct packed {
    logic a;
    logic b;
  } sccf_bridge_s;

  // South at the sensor energises side a
  function automatic sccf_bridge_s sccf_polar_drive(input logic south);
    sccf_bridge_s d;
    d.a = south;
    d.b = ~south;
    return d;
  endfunction

endpackage
`default_nettype wire

// File: sccf_timer.sv
`timescale 1ns/1ps
`default_nettype none
module sccf_timer #(
  parameter int unsigned CNT_W = 32,
  parameter int unsigned LIMIT = 16
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic run,
  output logic done
);

  localparam logic [CNT_W-1:0] LIMIT_C = CNT_W'(LIMIT);

  logic [CNT_W-1:0] cnt_reg;

  // Counts while run is high, clears the moment it drops; saturates at the limit
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_reg <= '0;
    end
    else if (clk_en)
    begin
      if (!run)
      begin
        cnt_reg <= '0;
      end
      else if (cnt_reg != LIMIT_C)
      begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  assign done = run && (cnt_reg == LIMIT_C);

endmodule // sccf_timer
`default_nettype wire

// File: sccf_soft.sv
`timescale 1ns/1ps
`default_nettype none
module sccf_soft #(
  parameter int unsigned SOFT_CYC = sccf_pkg::SOFT_SW_CYC,
  parameter int unsigned LEVEL_W = sccf_pkg::SOFT_LEVEL_W
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic south,
  input wire logic snap,
  output sccf_pkg::sccf_bridge_s drive,
  output logic busy
);

  localparam int unsigned RAMP_W = $clog2(SOFT_CYC + 1);
  localparam logic [RAMP_W-1:0] RAMP_LAST = RAMP_W'(SOFT_CYC - 1);

  logic tgt_reg;
  logic old_reg;
  logic busy_reg;
  logic [RAMP_W-1:0] ramp_reg;
  logic [LEVEL_W-1:0] saw_reg;
  logic [LEVEL_W-1:0] level;

  // Polarity change starts a crossfade from old to new side
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tgt_reg <= 1'b0;
      old_reg <= 1'b0;
      busy_reg <= 1'b0;
      ramp_reg <= '0;
    end
    else if (clk_en)
    begin
      if (snap)
      begin
        tgt_reg <= south;
        old_reg <= south;
        busy_reg <= 1'b0;
        ramp_reg <= '0;
      end
      else if (south != tgt_reg)
      begin
        old_reg <= tgt_reg;
        tgt_reg <= south;
        busy_reg <= 1'b1;
        ramp_reg <= '0;
      end
      else if (busy_reg)
      begin
        if (ramp_reg == RAMP_LAST)
        begin
          busy_reg <= 1'b0;
        end
        else
        begin
          ramp_reg <= ramp_reg + 1'b1;
        end
      end
    end
  end

  // Free-running sawtooth compared against the ramp level
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      saw_reg <= '0;
    end
    else if (clk_en)
    begin
      saw_reg <= saw_reg + 1'b1;
    end
  end

  assign level = LEVEL_W'((32'(ramp_reg) << LEVEL_W) / SOFT_CYC);
  assign busy = busy_reg;

  // New side duty rises linearly over the transition
  always_comb
  begin
    if (busy_reg && (saw_reg >= level))
    begin
      drive = sccf_pkg::sccf_polar_drive(old_reg);
    end
    else
    begin
      drive = sccf_pkg::sccf_polar_drive(tgt_reg);
    end
  end

endmodule // sccf_soft
`default_nettype wire

// File: sccf_fan_ctrl.sv
// Contract
// - Tach output inverts at each commutation edge of side a in rotation.
// - Locked south: b held low, a pulsed with lock on/off pattern.
// - Locked north: a held low, b pulsed with lock on/off pattern.
// - Each lock retry energises coil for the 420 ms on-window.
// - Drive-off interval after lock lasts ten times the on-window.
// - PWM low beyond 65 ms timeout drives both bridge outputs low.
// - That timeout clears pending lock off timer and enters standby.
// - First PWM high after standby starts straight in on-time phase.
// - After waking, wait 100 us for Hall settling before commutating.
// - Standby releases the open-drain tach switch so it floats high.
// - Overvoltage switches off all bridge drive and enters standby.
// - Active bridge side gated by PWM so drive duty tracks input.
// - Commutation ramps coil current gradually between polarities.
// - Soft commutation transition lasts typically 200 us.
`timescale 1ns/1ps
`default_nettype none
module sccf_fan_ctrl #(
  parameter int unsigned LOCK_ON_CYC = sccf_pkg::LOCK_ON_CYC,
  parameter int unsigned LOCK_OFF_CYC = sccf_pkg::LOCK_OFF_CYC,
  parameter int unsigned STBY_CYC = sccf_pkg::STBY_CYC,
  parameter int unsigned HALL_SETTLE_CYC = sccf_pkg::HALL_SETTLE_CYC,
  parameter int unsigned SOFT_SW_CYC = sccf_pkg::SOFT_SW_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic pwm_in,
  input wire logic hall_south,
  input wire logic ov_detect,
  output logic bridge_out_a,
  output logic bridge_out_b,
  input wire logic tach_output_level,
  output logic tach_output_data,
  output logic tach_output_oe,
  output logic standby
);

  sccf_pkg::sccf_state_e state_reg;
  sccf_pkg::sccf_state_e state_next;
  sccf_pkg::sccf_bridge_s soft_drive;
  logic hall_prev_reg;
  logic hall_edge;
  logic low_done;
  logic settle_done;
  logic lock_done;
  logic off_done;
  logic low_run;
  logic settle_run;
  logic lock_run;
  logic off_run;
  logic soft_snap;
  logic bridge_a_reg;
  logic bridge_b_reg;
  logic tach_oe_reg;
  logic tach_o_reg;
  logic standby_reg;
  logic tach_unused;

  // Pad level is not needed; the switch only ever pulls low
  assign tach_unused = tach_output_level;

  // Hall latch is taken as synchronous; edge marks a commutation
  // Reset level may differ from the pin; harmless, edges only count in run
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hall_prev_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      hall_prev_reg <= hall_south;
    end
  end

  assign hall_edge = (hall_south != hall_prev_reg);

  // Standby not counted from within standby itself
  assign low_run = !pwm_in && (state_reg != sccf_pkg::ST_STANDBY);
  // Settle restarts on every wake, even after a short standby
  assign settle_run = (state_reg == sccf_pkg::ST_SETTLE);
  // Any commutation restarts the lock window, so only a stalled rotor expires it
  assign lock_run = (state_reg == sccf_pkg::ST_RUN) && !hall_edge;
  // Off timer clears whenever the state leaves lock-off
  assign off_run = (state_reg == sccf_pkg::ST_LOCK_OFF);

  sccf_timer #(
    .CNT_W(sccf_pkg::TIMER_W),
    .LIMIT(STBY_CYC)
  ) u_low_timer (
    .clk(clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .run(low_run),
    .done(low_done)
  );

  sccf_timer #(
    .CNT_W(sccf_pkg::TIMER_W),
    .LIMIT(HALL_SETTLE_CYC)
  ) u_settle_timer (
    .clk(clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .run(settle_run),
    .done(settle_done)
  );

  sccf_timer #(
    .CNT_W(sccf_pkg::TIMER_W),
    .LIMIT(LOCK_ON_CYC)
  ) u_lock_timer (
    .clk(clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .run(lock_run),
    .done(lock_done)
  );

  sccf_timer #(
    .CNT_W(sccf_pkg::TIMER_W),
    .LIMIT(LOCK_OFF_CYC)
  ) u_off_timer (
    .clk(clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .run(off_run),
    .done(off_done)
  );

  // Ramp is only meaningful once commutation is live
  assign soft_snap = (state_reg == sccf_pkg::ST_STANDBY) || (state_reg == sccf_pkg::ST_SETTLE);

  sccf_soft #(
    .SOFT_CYC(SOFT_SW_CYC),
    .LEVEL_W(sccf_pkg::SOFT_LEVEL_W)
  ) u_soft (
    .clk(clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .south(hall_south),
    .snap(soft_snap),
    .drive(soft_drive),
    .busy()
  );

  // Overvoltage outranks every state, including wake from standby
  always_comb
  begin
    state_next = state_reg;
    if (ov_detect)
    begin
      state_next = sccf_pkg::ST_STANDBY;
    end
    else
    begin
      unique case (state_reg)
        sccf_pkg::ST_STANDBY:
        begin
          // Wake goes through settling, never through an off interval
          if (pwm_in)
          begin
            state_next = sccf_pkg::ST_SETTLE;
          end
        end
        sccf_pkg::ST_SETTLE:
        begin
          if (low_done)
          begin
            state_next = sccf_pkg::ST_STANDBY;
          end
          else if (settle_done)
          begin
            state_next = sccf_pkg::ST_RUN;
          end
        end
        sccf_pkg::ST_RUN:
        begin
          if (low_done)
          begin
            state_next = sccf_pkg::ST_STANDBY;
          end
          else if (lock_done)
          begin
            state_next = sccf_pkg::ST_LOCK_OFF;
          end
        end
        sccf_pkg::ST_LOCK_OFF:
        begin
          if (low_done)
          begin
            state_next = sccf_pkg::ST_STANDBY;
          end
          else if (off_done)
          begin
            state_next = sccf_pkg::ST_RUN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= sccf_pkg::ST_STANDBY;
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
    end
  end

  // Locked rotor keeps one Hall polarity, so the same path pulses one side
  // Registered on state_next so drive stops on the edge that leaves run
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bridge_a_reg <= 1'b0;
      bridge_b_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      if ((state_next == sccf_pkg::ST_RUN) && pwm_in)
      begin
        bridge_a_reg <= soft_drive.a;
        bridge_b_reg <= soft_drive.b;
      end
      else
      begin
        bridge_a_reg <= 1'b0;
        bridge_b_reg <= 1'b0;
      end
    end
  end

  // Tach follows commutation, not the PWM chopping of side a
  // Limitation: tach holds through lock-off, so coasting there goes unreported
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tach_oe_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      if (state_next == sccf_pkg::ST_STANDBY)
      begin
        tach_oe_reg <= 1'b0;
      end
      else if (state_reg == sccf_pkg::ST_SETTLE)
      begin
        tach_oe_reg <= hall_south;
      end
      else if ((state_reg == sccf_pkg::ST_RUN) && hall_edge)
      begin
        tach_oe_reg <= ~tach_oe_reg;
      end
    end
  end

  // Open-drain switch only ever pulls low
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tach_o_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      tach_o_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      // Taken from state_next so the flag and bridge shut-off share one edge
      standby_reg <= 1'b1;
    end
    else if (clk_en)
    begin
      standby_reg <= (state_next == sccf_pkg::ST_STANDBY);
    end
  end

  assign bridge_out_a = bridge_a_reg;
  assign bridge_out_b = bridge_b_reg;
  assign tach_output_data = tach_o_reg;
  assign tach_output_oe = tach_oe_reg;
  assign standby = standby_reg;

endmodule // sccf_fan_ctrl
`default_nettype wire

// File: sccf_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sccf_checker #(
  parameter int unsigned STBY_CYC = 300
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic pwm_in,
  input wire logic hall_south,
  input wire logic ov_detect,
  input wire logic bridge_out_a,
  input wire logic bridge_out_b,
  input wire logic tach_output_level,
  input wire logic tach_output_data,
  input wire logic tach_output_oe,
  input wire logic standby
);
  logic [31:0] low_reg;
  // Consecutive sampled pwm-low cycles
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      low_reg <= '0;
    else if (clk_en)
      low_reg <= pwm_in ? '0 : low_reg + 32'h1;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  property p_no_short;
    !(bridge_out_a && bridge_out_b);
  endproperty
  a_no_short: assert property (p_no_short) else $error("both bridge sides on");
  property p_pwm_gate;
    clk_en && !pwm_in |=> !bridge_out_a && !bridge_out_b;
  endproperty
  a_pwm_gate: assert property (p_pwm_gate) else $error("drive with pwm low");
  property p_ov_off;
    clk_en && ov_detect |=> standby && !bridge_out_a && !bridge_out_b && !tach_output_oe;
  endproperty
  a_ov_off: assert property (p_ov_off) else $error("overvoltage not shut down");
  property p_stby_quiet;
    standby |-> !bridge_out_a && !bridge_out_b && !tach_output_oe;
  endproperty
  a_stby_quiet: assert property (p_stby_quiet) else $error("active in standby");
  property p_wake;
    clk_en && standby && pwm_in && !ov_detect |=> !standby;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on pwm high");
  property p_settle;
    $fell(standby) |-> (!bridge_out_a && !bridge_out_b) [*8];
  endproperty
  a_settle: assert property (p_settle) else $error("drive during hall settle");
  property p_timeout;
    low_reg > STBY_CYC + 3 |-> standby;
  endproperty
  a_timeout: assert property (p_timeout) else $error("no standby after pwm low");
  // Wake loads the tach from the hall, so two quiet cycles are excluded
  property p_tach;
    $changed(tach_output_oe) && !standby && !$past(standby) && !$past(standby, 2)
      |-> $past(hall_south) != $past(hall_south, 2);
  endproperty
  a_tach: assert property (p_tach) else $error("tach edge without commutation");
endmodule // sccf_checker
bind sccf_fan_ctrl sccf_checker #(.STBY_CYC(STBY_CYC)) u_sccf_checker (
  .clk(clk), .arst_n(arst_n), .clk_en(clk_en), .pwm_in(pwm_in), .hall_south(hall_south),
  .ov_detect(ov_detect), .bridge_out_a(bridge_out_a), .bridge_out_b(bridge_out_b),
  .tach_output_level(tach_output_level), .tach_output_data(tach_output_data),
  .tach_output_oe(tach_output_oe), .standby(standby));
`default_nettype wire

// File: sccf_motor.sv
`timescale 1ns/1ps
`default_nettype none
module sccf_motor #(
  parameter int unsigned HALF = 150
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic drive_a,
  input wire logic drive_b,
  input wire logic stall,
  output logic hall_south
);
  logic spin_reg;
  logic [15:0] pos_reg;
  // Inertia: keeps turning once driven, until held still
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      spin_reg <= 1'b0;
    else
      spin_reg <= !stall && (spin_reg || drive_a || drive_b);
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      pos_reg <= '0;
      hall_south <= 1'b1;
    end
    else if (spin_reg && !stall)
    begin
      pos_reg <= (pos_reg == HALF - 1) ? '0 : pos_reg + 16'h1;
      if (pos_reg == HALF - 1)
        hall_south <= !hall_south;
    end
endmodule // sccf_motor
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int LON = 200;
  localparam int LOFF = 2000;
  localparam int STBY = 5000;
  localparam int SETL = 20;
  localparam int SOFT = 64;
  localparam int PER = 4000; // 25 kHz pwm at 100 MHz
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic clk_en = 1'b1;
  logic pwm_in = 1'b0;
  logic ov_detect = 1'b0;
  logic stall = 1'b0;
  logic hall_south, bridge_out_a, bridge_out_b, tach_o, tach_oe, standby;
  // External pull-up on the tach pad
  wire logic tach_pad = tach_oe ? 1'b0 : 1'b1;
  int n_fail = 0;
  int num_checks = 0;
  sccf_fan_ctrl #(.LOCK_ON_CYC(LON), .LOCK_OFF_CYC(LOFF), .STBY_CYC(STBY),
    .HALL_SETTLE_CYC(SETL), .SOFT_SW_CYC(SOFT)) u_sccf_fan_ctrl (
    .clk(clk), .arst_n(arst_n), .clk_en(clk_en), .pwm_in(pwm_in), .hall_south(hall_south),
    .ov_detect(ov_detect), .bridge_out_a(bridge_out_a), .bridge_out_b(bridge_out_b),
    .tach_output_level(tach_pad), .tach_output_data(tach_o), .tach_output_oe(tach_oe),
    .standby(standby));
  sccf_motor u_sccf_motor (.clk(clk), .arst_n(arst_n), .drive_a(bridge_out_a),
    .drive_b(bridge_out_b), .stall(stall), .hall_south(hall_south));
  initial forever #5 clk = ~clk;
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input int lo, input int hi, input logic [31:0] got);
    num_checks++;
    if (^got === 1'bx || got < lo || got > hi)
    begin
      n_fail++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic until_drive(output int n, input int lim);
    n = 0;
    while (!(bridge_out_a || bridge_out_b) && n < lim)
    begin
      tick(1);
      n++;
    end
  endtask
  task automatic give_verdict;
    if (n_fail == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic t_wake;
    int n;
    chk("standby", 1, 1, standby);
    chk("tach oe", 0, 0, tach_oe);
    chk("tach data", 0, 0, tach_o);
    pwm_in = 1'b1;
    tick(2);
    chk("standby", 0, 0, standby);
    until_drive(n, 100);
    chk("settle", SETL - 1, SETL + 4, n);
    tick(1);
    chk("pole", hall_south ? 2 : 1, hall_south ? 2 : 1, {bridge_out_a, bridge_out_b});
  endtask
  task automatic t_soft;
    int last, ht, tt;
    logic h, t;
    h = hall_south;
    for (int i = 0; i < 400 && hall_south === h; i++)
      tick(1);
    last = 0;
    for (int i = 0; i < SOFT + 8; i++)
    begin
      if ({bridge_out_a, bridge_out_b} !== {hall_south, !hall_south})
        last = i;
      tick(1);
    end
    chk("soft span", 2, SOFT + 2, last);
    ht = 0;
    tt = 0;
    h = hall_south;
    t = tach_oe;
    repeat (1000)
    begin
      tick(1);
      ht += (hall_south !== h);
      tt += (tach_oe !== t);
      h = hall_south;
      t = tach_oe;
    end
    chk("hall edges", 5, 8, ht);
    chk("tach edges", ht - 1, ht + 1, tt);
  endtask
  // Frozen block must hold against pwm low and overvoltage; no Hall edge inside
  task automatic t_freeze;
    logic h;
    int e;
    h = hall_south;
    for (int i = 0; i < 400 && hall_south === h; i++)
      tick(1);
    tick(SOFT + 4);
    h = hall_south;
    e = {h, !h, h, 1'b0, 1'b0};
    clk_en = 1'b0;
    pwm_in = 1'b0;
    ov_detect = 1'b1;
    tick(20);
    chk("frozen", e, e, {bridge_out_a, bridge_out_b, tach_oe, standby, tach_o});
    ov_detect = 1'b0;
    pwm_in = 1'b1;
    clk_en = 1'b1;
  endtask
  // Low phase stays under the standby timeout
  task automatic t_duty;
    int on;
    for (int d = 1; d <= 3; d += 2)
    begin
      on = 0;
      for (int i = 0; i < 2 * PER; i++)
      begin
        pwm_in = (i % PER) < d * PER / 4;
        tick(1);
        on += (bridge_out_a || bridge_out_b);
      end
      chk("duty", d * PER / 2 - 2, d * PER / 2 + 2, on);
    end
    pwm_in = 1'b1;
  endtask
  task automatic t_lock(input logic pole);
    int n, idle;
    for (int i = 0; i < 400 && hall_south !== pole; i++)
      tick(1);
    stall = 1'b1;
    idle = 0;
    for (int i = 0; i < 800 && idle < 10; i++)
    begin
      tick(1);
      idle = (bridge_out_a || bridge_out_b) ? 0 : idle + 1;
    end
    until_drive(n, LOFF + 50);
    chk("lock off", LOFF - 3, LOFF + 3, n + idle);
    n = 0;
    while ((pole ? bridge_out_a && !bridge_out_b : bridge_out_b && !bridge_out_a)
      && n < LON + 50)
    begin
      tick(1);
      n++;
    end
    chk("lock on", LON - 3, LON + 3, n);
    chk("lock side", 0, 0, {bridge_out_a, bridge_out_b});
  endtask
  // Entered mid lock-off so a pending off interval must be dropped
  task automatic t_stby;
    int n;
    pwm_in = 1'b0;
    n = 0;
    while (standby !== 1'b1 && n < STBY + 50)
    begin
      tick(1);
      n++;
    end
    chk("timeout", STBY - 1, STBY + 3, n);
    chk("drive off", 0, 0, {bridge_out_a, bridge_out_b, tach_oe});
    pwm_in = 1'b1;
    tick(1);
    until_drive(n, LOFF);
    chk("quick start", SETL - 1, SETL + 4, n);
  endtask
  task automatic t_ov;
    int n;
    stall = 1'b0;
    ov_detect = 1'b1;
    tick(2);
    chk("ov off", 8, 8, {standby, bridge_out_a, bridge_out_b, tach_oe});
    ov_detect = 1'b0;
    until_drive(n, LOFF);
    chk("ov restart", SETL - 1, SETL + 5, n);
  endtask
  initial
  begin
    tick(16);
    arst_n = 1'b1;
    tick(2);
    t_wake();
    t_soft();
    t_freeze();
    t_duty();
    t_lock(1'b1);
    t_stby();
    stall = 1'b0;
    tick(300);
    t_lock(1'b0);
    t_ov();
    give_verdict();
  end
  initial
  begin
    tick(80000);
    n_fail++;
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
